// ---- shared/lpt_pkg.sv ----
// Package: register map, reset values, timing constants and decoders for the light/prox timing block
package lpt_pkg;

   // Register offsets
   localparam logic [4:0] ADDR_ENABLE = 5'h00;
   localparam logic [4:0] ADDR_LIGHT_TIME = 5'h01;
   localparam logic [4:0] ADDR_PROX_TIME = 5'h02;
   localparam logic [4:0] ADDR_WAIT_TIME = 5'h03;
   localparam logic [4:0] ADDR_LIGHT_LOW_LO = 5'h04;
   localparam logic [4:0] ADDR_LIGHT_LOW_HI = 5'h05;
   localparam logic [4:0] ADDR_LIGHT_HIGH_LO = 5'h06;
   localparam logic [4:0] ADDR_LIGHT_HIGH_HI = 5'h07;
   localparam logic [4:0] ADDR_PROX_LOW_LO = 5'h08;
   localparam logic [4:0] ADDR_PROX_LOW_HI = 5'h09;
   localparam logic [4:0] ADDR_PROX_HIGH_LO = 5'h0A;
   localparam logic [4:0] ADDR_PROX_HIGH_HI = 5'h0B;
   localparam logic [4:0] ADDR_PERSIST = 5'h0C;
   localparam logic [4:0] ADDR_CONFIG = 5'h0D;
   localparam logic [4:0] ADDR_COMMAND = 5'h10;
   localparam logic [4:0] ADDR_STATUS = 5'h13;

   // Enable and config register bit positions
   localparam int EN_POWER_ON = 0;
   localparam int EN_LIGHT = 1;
   localparam int EN_PROX = 2;
   localparam int EN_WAIT = 3;
   localparam int EN_LIGHT_IRQ = 4;
   localparam int EN_PROX_IRQ = 5;
   localparam int CFG_LONG_WAIT = 1;

   // Reset values
   localparam logic [7:0] RST_TIME = 8'hFF;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // Clear command codes
   localparam logic [4:0] CMD_CLEAR_PROX = 5'h05;
   localparam logic [4:0] CMD_CLEAR_LIGHT = 5'h06;
   localparam logic [4:0] CMD_CLEAR_BOTH = 5'h07;

   // Timing
   localparam real CLK_PERIOD_NS = 25.0;
   localparam real STEP_TIME_MS = 2.73;
   localparam int STEP_CYCLES = int'(STEP_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int LONG_WAIT_FACTOR = 12;
   localparam int PRESC_W = 17;
   localparam logic [8:0] FULL_COUNT = 9'h100;

   // Sequencer states
   typedef enum logic [3:0]
   {
      S_IDLE = 4'b0001,
      S_PROX = 4'b0010,
      S_LIGHT = 4'b0100,
      S_WAIT = 4'b1000
   } lpt_state_t;

   // Step count from a two's-complement time value
   function automatic logic [8:0] stepCount(input logic [7:0] timeVal);
      stepCount = FULL_COUNT - {1'b0, timeVal};
   endfunction : stepCount

   // Light persistence code to run length; zero means every cycle
   function automatic logic [5:0] lightRunLength(input logic [3:0] code);
      logic [5:0] c;
      c = {2'b00, code};
      if (code < 4'h4)
         lightRunLength = c;
      else
         lightRunLength = 6'((c - 6'h03) * 6'h05);
   endfunction : lightRunLength

endpackage : lpt_pkg

// ---- hdl/lpt_step_timer.sv ----
// Interval timer: counts 2.73 ms steps, optionally stretched for long wait
`timescale 1ns/100ps
`default_nettype none
module lpt_step_timer
   import lpt_pkg::*;
#(
   parameter int STEP_LEN = STEP_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control
   input wire logic start,
   input wire logic abort,
   input wire logic [8:0] intervals,
   input wire logic longStep,
   // Status
   output logic busy,
   output logic done
);

   typedef struct packed
   {
      logic busy;
      logic done;
      logic [3:0] sub;
      logic [8:0] left;
      logic [PRESC_W-1:0] presc;
   } lpt_timer_t;

   lpt_timer_t r_q;
   lpt_timer_t r_d;
   logic [3:0] subLast;

   always_comb
   begin
      r_d = r_q;
      r_d.done = 1'b0;
      subLast = longStep ? 4'(LONG_WAIT_FACTOR - 1) : 4'h0;
      if (abort)
         r_d.busy = 1'b0;
      else if (start)
      begin
         r_d.busy = 1'b1;
         r_d.left = intervals;
         r_d.presc = '0;
         r_d.sub = 4'h0;
      end
      else if (r_q.busy)
      begin
         if (r_q.presc == PRESC_W'(STEP_LEN - 1))
         begin
            r_d.presc = '0;
            if (r_q.sub == subLast)
            begin
               r_d.sub = 4'h0;
               if (r_q.left == 9'h001)
               begin
                  r_d.busy = 1'b0;
                  r_d.done = 1'b1;
               end
               else
                  r_d.left = r_q.left - 9'h001;
            end
            else
               r_d.sub = r_q.sub + 4'h1;
         end
         else
            r_d.presc = r_q.presc + PRESC_W'(1);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         r_q <= '0;
      else
         r_q <= r_d;
   end

   assign busy = r_q.busy;
   assign done = r_q.done;

   a_timer_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      r_q.busy && !start && !abort && r_q.left > 9'h001 |=> r_q.busy)
      else $error("timer stopped early");

endmodule : lpt_step_timer
`default_nettype wire

// ---- hdl/lpt_persist_filter.sv ----
// Persistence filter: counts consecutive out-of-range results and holds a pending interrupt
`timescale 1ns/100ps
`default_nettype none
module lpt_persist_filter
   import lpt_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Evaluation
   input wire logic evalValid,
   input wire logic outOfRange,
   input wire logic [5:0] runLength,
   // Control
   input wire logic maskEn,
   input wire logic clear,
   // Status
   output logic pending
);

   typedef struct packed
   {
      logic [5:0] cnt;
      logic pending;
   } lpt_filter_t;

   lpt_filter_t r_q;
   lpt_filter_t r_d;
   logic fire;

   always_comb
   begin
      r_d = r_q;
      fire = 1'b0;
      if (evalValid)
      begin
         if (runLength == 6'h00)
         begin
            fire = 1'b1;
            r_d.cnt = 6'h00;
         end
         else if (!outOfRange)
            r_d.cnt = 6'h00;
         else if (r_q.cnt + 6'h01 >= runLength)
         begin
            fire = 1'b1;
            r_d.cnt = 6'h00;
         end
         else
            r_d.cnt = r_q.cnt + 6'h01;
      end
      // Set wins over a clear in the same cycle
      r_d.pending = (r_q.pending && !clear) || (fire && maskEn);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         r_q <= '0;
      else
         r_q <= r_d;
   end

   assign pending = r_q.pending;

   sequence sLastOfRun;
      evalValid && outOfRange && runLength != 6'h00 && r_q.cnt + 6'h01 == runLength;
   endsequence

   a_every_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      evalValid && runLength == 6'h00 && maskEn |=> pending)
      else $error("zero code did not interrupt");
   a_run_fires: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sLastOfRun and maskEn |=> pending && r_q.cnt == 6'h00)
      else $error("full run did not interrupt");
   a_inrange_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
      evalValid && !outOfRange |=> r_q.cnt == 6'h00)
      else $error("in-range result kept count");
   a_mask_gates: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !maskEn && !pending |=> !pending)
      else $error("masked interrupt raised");
   a_pending_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pending && !clear |=> pending)
      else $error("pending dropped without clear");
   a_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
      evalValid && outOfRange && runLength != 6'h00 && r_q.cnt + 6'h01 < runLength
      |=> r_q.cnt == $past(r_q.cnt) + 6'h01)
      else $error("count did not advance");

endmodule : lpt_persist_filter
`default_nettype wire

// ---- hdl/lpt_timing_irq.sv ----
// Top: register file, measurement sequencer and interrupt qualification
`timescale 1ns/100ps
`default_nettype none
module lpt_timing_irq
   import lpt_pkg::*;
#(
   parameter int STEP_LEN = STEP_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [4:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Conversion results
   input wire logic [15:0] channel0Result,
   input wire logic [15:0] proxResult,
   // Sequencer status
   output logic proxIntegrate,
   output logic lightIntegrate,
   output logic waitActive,
   output logic proxCycleDone,
   output logic lightCycleDone,
   // Interrupt pin, open drain
   output logic intPinOut,
   output logic intPinOe
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed
   {
      lpt_state_t state;
      logic [5:0] enable;
      logic [7:0] lightTime;
      logic [7:0] proxTime;
      logic [7:0] waitTime;
      logic [15:0] lightLow;
      logic [15:0] lightHigh;
      logic [15:0] proxLow;
      logic [15:0] proxHigh;
      logic [7:0] persist;
      logic longWait;
      logic [7:0] rdata;
      logic proxDone;
      logic lightDone;
   } lpt_top_t;

   lpt_top_t r_q;
   lpt_top_t r_d;

   logic timerStart;
   logic timerAbort;
   logic [8:0] timerIntervals;
   logic timerLong;
   logic timerBusy;
   logic timerDone;
   logic proxEval;
   logic lightEval;
   logic proxOut;
   logic lightOut;
   logic proxPending;
   logic lightPending;
   logic cmdWrite;
   logic clearProx;
   logic clearLight;
   logic powerOn;
   logic lightEn;
   logic proxEn;
   logic waitEn;

   assign powerOn = r_q.enable[EN_POWER_ON];
   assign lightEn = r_q.enable[EN_LIGHT];
   assign proxEn = r_q.enable[EN_PROX];
   assign waitEn = r_q.enable[EN_WAIT];

   ////////////////////////////////////////////////////////////////////////////
   // Clear commands

   assign cmdWrite = regWr && regAddr == ADDR_COMMAND;
   assign clearProx = cmdWrite && (regWdata[4:0] == CMD_CLEAR_PROX || regWdata[4:0] == CMD_CLEAR_BOTH);
   assign clearLight = cmdWrite && (regWdata[4:0] == CMD_CLEAR_LIGHT || regWdata[4:0] == CMD_CLEAR_BOTH);

   ////////////////////////////////////////////////////////////////////////////
   // Threshold comparison, inclusive bounds

   assign proxEval = r_q.state == S_PROX && timerDone;
   assign lightEval = r_q.state == S_LIGHT && timerDone;
   assign proxOut = proxResult < r_q.proxLow || proxResult > r_q.proxHigh;
   // Only channel 0 feeds the light comparison
   assign lightOut = channel0Result < r_q.lightLow || channel0Result > r_q.lightHigh;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes, reads and sequencer

   always_comb
   begin
      r_d = r_q;
      r_d.rdata = 8'h00;
      r_d.proxDone = proxEval;
      r_d.lightDone = lightEval;
      timerStart = 1'b0;
      timerAbort = 1'b0;
      timerIntervals = 9'h000;
      timerLong = 1'b0;

      if (regWr)
      begin
         case (regAddr)
            ADDR_ENABLE: r_d.enable = regWdata[5:0];
            ADDR_LIGHT_TIME: r_d.lightTime = regWdata;
            ADDR_PROX_TIME: r_d.proxTime = regWdata;
            ADDR_WAIT_TIME: r_d.waitTime = regWdata;
            ADDR_LIGHT_LOW_LO: r_d.lightLow[7:0] = regWdata;
            ADDR_LIGHT_LOW_HI: r_d.lightLow[15:8] = regWdata;
            ADDR_LIGHT_HIGH_LO: r_d.lightHigh[7:0] = regWdata;
            ADDR_LIGHT_HIGH_HI: r_d.lightHigh[15:8] = regWdata;
            ADDR_PROX_LOW_LO: r_d.proxLow[7:0] = regWdata;
            ADDR_PROX_LOW_HI: r_d.proxLow[15:8] = regWdata;
            ADDR_PROX_HIGH_LO: r_d.proxHigh[7:0] = regWdata;
            ADDR_PROX_HIGH_HI: r_d.proxHigh[15:8] = regWdata;
            ADDR_PERSIST: r_d.persist = regWdata;
            ADDR_CONFIG: r_d.longWait = regWdata[CFG_LONG_WAIT];
            default: r_d.persist = r_q.persist;
         endcase
      end

      if (regRd)
      begin
         case (regAddr)
            ADDR_ENABLE: r_d.rdata = {2'b00, r_q.enable};
            ADDR_LIGHT_TIME: r_d.rdata = r_q.lightTime;
            ADDR_PROX_TIME: r_d.rdata = r_q.proxTime;
            ADDR_WAIT_TIME: r_d.rdata = r_q.waitTime;
            ADDR_LIGHT_LOW_LO: r_d.rdata = r_q.lightLow[7:0];
            ADDR_LIGHT_LOW_HI: r_d.rdata = r_q.lightLow[15:8];
            ADDR_LIGHT_HIGH_LO: r_d.rdata = r_q.lightHigh[7:0];
            ADDR_LIGHT_HIGH_HI: r_d.rdata = r_q.lightHigh[15:8];
            ADDR_PROX_LOW_LO: r_d.rdata = r_q.proxLow[7:0];
            ADDR_PROX_LOW_HI: r_d.rdata = r_q.proxLow[15:8];
            ADDR_PROX_HIGH_LO: r_d.rdata = r_q.proxHigh[7:0];
            ADDR_PROX_HIGH_HI: r_d.rdata = r_q.proxHigh[15:8];
            ADDR_PERSIST: r_d.rdata = r_q.persist;
            ADDR_CONFIG: r_d.rdata = {6'h00, r_q.longWait, 1'b0};
            ADDR_STATUS: r_d.rdata = {r_q.state, 1'b0, timerBusy, proxPending, lightPending};
            default: r_d.rdata = 8'h00;
         endcase
      end

      // Power off stops everything at once; a running step is dropped
      if (!powerOn)
      begin
         r_d.state = S_IDLE;
         timerAbort = r_q.state != S_IDLE;
      end
      else
      begin
         unique case (r_q.state)
            S_IDLE:
            begin
               if (proxEn)
               begin
                  r_d.state = S_PROX;
                  timerStart = 1'b1;
                  timerIntervals = stepCount(r_q.proxTime);
               end
               else if (lightEn)
               begin
                  r_d.state = S_LIGHT;
                  timerStart = 1'b1;
                  timerIntervals = stepCount(r_q.lightTime);
               end
            end
            S_PROX:
            begin
               if (timerDone)
               begin
                  if (lightEn)
                  begin
                     r_d.state = S_LIGHT;
                     timerStart = 1'b1;
                     timerIntervals = stepCount(r_q.lightTime);
                  end
                  else if (waitEn)
                  begin
                     r_d.state = S_WAIT;
                     timerStart = 1'b1;
                     timerIntervals = stepCount(r_q.waitTime);
                     timerLong = r_q.longWait;
                  end
                  else
                     r_d.state = S_IDLE;
               end
            end
            S_LIGHT:
            begin
               if (timerDone)
               begin
                  if (waitEn)
                  begin
                     r_d.state = S_WAIT;
                     timerStart = 1'b1;
                     timerIntervals = stepCount(r_q.waitTime);
                     timerLong = r_q.longWait;
                  end
                  else
                     r_d.state = S_IDLE;
               end
            end
            S_WAIT:
            begin
               timerLong = r_q.longWait;
               // Dropping wait enable ends the wait at once
               if (timerDone || !waitEn)
               begin
                  r_d.state = S_IDLE;
                  timerAbort = !timerDone;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         r_q <= '0;
         r_q.state <= S_IDLE;
         r_q.lightTime <= RST_TIME;
         r_q.proxTime <= RST_TIME;
         r_q.waitTime <= RST_TIME;
         r_q.persist <= RST_ZERO;
      end
      else
         r_q <= r_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer and filters

   lpt_step_timer #(
      .STEP_LEN(STEP_LEN)
   ) u_timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(timerStart),
      .abort(timerAbort),
      .intervals(timerIntervals),
      .longStep(timerLong),
      .busy(timerBusy),
      .done(timerDone)
   );

   // Separate counters keep one function's run from masking the other's
   lpt_persist_filter u_prox_filter (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .evalValid(proxEval),
      .outOfRange(proxOut),
      .runLength({2'b00, r_q.persist[7:4]}),
      .maskEn(r_q.enable[EN_PROX_IRQ]),
      .clear(clearProx),
      .pending(proxPending)
   );

   lpt_persist_filter u_light_filter (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .evalValid(lightEval),
      .outOfRange(lightOut),
      .runLength(lightRunLength(r_q.persist[3:0])),
      .maskEn(r_q.enable[EN_LIGHT_IRQ]),
      .clear(clearLight),
      .pending(lightPending)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign regRdata = r_q.rdata;
   assign proxIntegrate = r_q.state == S_PROX;
   assign lightIntegrate = r_q.state == S_LIGHT;
   assign waitActive = r_q.state == S_WAIT;
   assign proxCycleDone = r_q.proxDone;
   assign lightCycleDone = r_q.lightDone;
   // Pin is pulled low while either interrupt is pending
   assign intPinOut = 1'b0;
   assign intPinOe = proxPending || lightPending;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_light_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
      regWr && regAddr == ADDR_LIGHT_HIGH_HI |=> r_q.lightHigh[15:8] == $past(regWdata)
      && r_q.lightHigh[7:0] == $past(r_q.lightHigh[7:0]))
      else $error("light high threshold byte wrong");
   a_prox_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
      regWr && regAddr == ADDR_PROX_LOW_LO |=> r_q.proxLow[7:0] == $past(regWdata)
      && r_q.proxLow[15:8] == $past(r_q.proxLow[15:8]))
      else $error("prox low threshold byte wrong");
   a_no_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
      r_q.state != S_WAIT && !waitEn |=> r_q.state != S_WAIT)
      else $error("wait entered while disabled");
   a_light_steps: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timerStart && r_d.state == S_LIGHT && r_q.lightTime == 8'h00 |-> timerIntervals == 9'h100)
      else $error("light time zero not 256 steps");
   a_pin_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
      lightEval && lightOut && r_q.persist[3:0] == 4'h1 && r_q.enable[EN_LIGHT_IRQ] |=> intPinOe)
      else $error("light interrupt missing on pin");

   // Step counts, channel 0 comparison and pin behaviour seen from the top
   a_prox_steps: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timerStart && r_d.state == S_PROX && r_q.proxTime == 8'hFF |-> timerIntervals == 9'h001)
      else $error("prox time all ones not one step");
   a_wait_steps: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timerStart && r_d.state == S_WAIT && r_q.waitTime == 8'hFE |-> timerIntervals == 9'h002)
      else $error("wait time step count wrong");
   a_wait_long: assert property (@(posedge clk_sys) disable iff (!rst_n)
      timerStart && r_d.state == S_WAIT |-> timerLong == r_q.longWait)
      else $error("long wait not applied");
   a_ch0_compare: assert property (@(posedge clk_sys) disable iff (!rst_n)
      lightEval && channel0Result > r_q.lightHigh |-> lightOut)
      else $error("channel 0 above high not out of range");
   a_prox_every: assert property (@(posedge clk_sys) disable iff (!rst_n)
      proxEval && r_q.persist[7:4] == 4'h0 && r_q.enable[EN_PROX_IRQ] |=> intPinOe)
      else $error("prox code zero did not drive pin");
   a_prox_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !r_q.enable[EN_PROX_IRQ] && !proxPending |=> !proxPending)
      else $error("masked prox interrupt raised");
   a_clear_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmdWrite && regWdata[4:0] == CMD_CLEAR_BOTH && !proxEval && !lightEval |=> !intPinOe)
      else $error("clear both left pin asserted");
   a_filters_apart: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clearProx && !clearLight && lightPending |=> lightPending)
      else $error("prox clear dropped light interrupt");

endmodule : lpt_timing_irq
`default_nettype wire

// ---- sim/lpt_host_model.sv ----
// Host model: drives the register port and notes expected read data
`timescale 1ns/100ps
`default_nettype none
module lpt_host_model
   import lpt_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Register port
   output logic [4:0] regAddr,
   output logic [7:0] regWdata,
   output logic regWr,
   output logic regRd
);
   logic [7:0] expQ[$];
   initial
   begin
      regAddr = 5'h00;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One-cycle strobes; a gap edge between calls keeps drivers race free
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      expQ.push_back(e);
      @(posedge clk_sys);
      regRd <= 1'b0;
   endtask : rd
endmodule : lpt_host_model
`default_nettype wire

// ---- sim/test_lpt_timing_irq.sv ----
// Testbench for the light/prox timing and interrupt block
`timescale 1ns/100ps
`default_nettype none
module test_lpt_timing_irq;
   import lpt_pkg::*;
   localparam int SL = 4;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] channel0Result = 16'h0000;
   logic [15:0] proxResult = 16'h0000;
   logic [4:0] regAddr;
   logic [7:0] regWdata, regRdata, v;
   logic regWr, regRd, lightIntegrate, waitActive, proxCycleDone, lightCycleDone, intPinOe;
   logic proxIntegrate, intPinOut;
   logic rdPrev = 1'b0;
   logic [15:0] n0, n1;
   int failures = 0;
   int checked = 0;
   always #12.5 clk_sys = ~clk_sys;
   lpt_host_model i_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd));
   lpt_timing_irq #(.STEP_LEN(SL)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .channel0Result(channel0Result),
      .proxResult(proxResult), .proxIntegrate(proxIntegrate), .lightIntegrate(lightIntegrate),
      .waitActive(waitActive), .proxCycleDone(proxCycleDone), .lightCycleDone(lightCycleDone),
      .intPinOut(intPinOut), .intPinOe(intPinOe));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task automatic close_out;
      $display("counts: %0d failures, %0d checked", failures, checked);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   // Read data stands only the cycle after the strobe
   always @(posedge clk_sys)
   begin
      if (rdPrev)
         cmp({8'h00, regRdata}, {8'h00, i_host.expQ.pop_front()});
      rdPrev <= regRd;
   end
   function automatic logic sig(input int s);
      return (s == 0) ? lightIntegrate : (s == 1) ? waitActive : proxIntegrate;
   endfunction : sig
   // Second pass only: a write may land after the phase already latched its time
   task automatic meas(input int s, output logic [15:0] n);
      int k;
      repeat (2)
      begin
         k = 0;
         n = 16'h0000;
         while (sig(s) === 1'b1 && k < 3000) begin @(posedge clk_sys); k++; end
         while (sig(s) !== 1'b1 && k < 3000) begin @(posedge clk_sys); k++; end
         while (sig(s) === 1'b1 && n < 16'h0BB8) begin @(posedge clk_sys); n++; end
      end
   endtask : meas
   task automatic dn(input int s, input int c);
      int k;
      repeat (c)
      begin
         k = 0;
         do begin @(posedge clk_sys); k++; end
         while (((s == 0) ? proxCycleDone : lightCycleDone) !== 1'b1 && k < 5000);
      end
   endtask : dn
   task automatic clr(input logic [7:0] code, input logic e);
      i_host.wr(ADDR_COMMAND, code);
      @(posedge clk_sys);
      cmp({15'h0000, intPinOe}, {15'h0000, e});
      cmp({15'h0000, intPinOut}, 16'h0000);
   endtask : clr
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #2000000;
      failures++;
      close_out();
   end
   initial
   begin
      v = 8'($urandom(22075));
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Prox time left at all ones
      for (int a = 1; a <= 12; a++) i_host.rd(5'(a), (a < 4) ? RST_TIME : RST_ZERO);
      i_host.rd(5'h1F, 8'h00);
      for (int a = 4; a <= 11; a++)
      begin
         v = 8'($urandom);
         i_host.wr(5'(a), v);
         i_host.rd(5'(a), v);
      end
      $display("test registers done");
      i_host.wr(ADDR_WAIT_TIME, 8'hFF);
      i_host.wr(ADDR_ENABLE, 8'h03);
      meas(0, n0);
      i_host.wr(ADDR_LIGHT_TIME, 8'hFD);
      meas(0, n1);
      cmp(n1 - n0, 16'(2 * SL));
      i_host.wr(ADDR_LIGHT_TIME, 8'h00);
      meas(0, n1);
      cmp(n1 - n0, 16'(255 * SL));
      i_host.wr(ADDR_LIGHT_TIME, 8'hFF);
      meas(1, n1);
      cmp(n1, 16'h0000);
      i_host.wr(ADDR_ENABLE, 8'h0B);
      meas(1, n0);
      i_host.wr(ADDR_CONFIG, 8'h02);
      meas(1, n1);
      cmp(n1 - n0, 16'(11 * SL));
      i_host.wr(ADDR_CONFIG, 8'h00);
      i_host.wr(ADDR_WAIT_TIME, 8'hFE);
      meas(1, n1);
      cmp(n1 - n0, 16'(SL));
      i_host.wr(ADDR_ENABLE, 8'h05);
      meas(2, n0);
      i_host.wr(ADDR_PROX_TIME, 8'hFE);
      meas(2, n1);
      cmp(n1 - n0, 16'(SL));
      i_host.wr(ADDR_PROX_TIME, 8'hFF);
      $display("test timing done");
      i_host.wr(ADDR_ENABLE, 8'h00);
      i_host.rd(ADDR_STATUS, 8'h10);
      i_host.wr(ADDR_PROX_LOW_HI, 8'h01);
      i_host.wr(ADDR_PROX_HIGH_LO, 8'h00);
      i_host.wr(ADDR_PROX_HIGH_HI, 8'h02);
      i_host.wr(ADDR_PROX_LOW_LO, 8'h00);
      i_host.wr(ADDR_PERSIST, 8'h20);
      proxResult <= 16'h0300;
      i_host.wr(ADDR_ENABLE, 8'h25);
      dn(0, 1);
      cmp({15'h0000, intPinOe}, 16'h0000);
      dn(0, 1);
      cmp({15'h0000, intPinOe}, 16'h0001);
      clr(8'h05, 1'b0);
      dn(0, 1);
      cmp({15'h0000, intPinOe}, 16'h0000);
      proxResult <= 16'h0100;
      dn(0, 1);
      proxResult <= 16'h0300;
      dn(0, 1);
      cmp({15'h0000, intPinOe}, 16'h0000);
      dn(0, 1);
      cmp({15'h0000, intPinOe}, 16'h0001);
      clr(8'h05, 1'b0);
      i_host.wr(ADDR_ENABLE, 8'h05);
      dn(0, 3);
      cmp({15'h0000, intPinOe}, 16'h0000);
      proxResult <= 16'h0180;
      i_host.wr(ADDR_PERSIST, 8'h00);
      i_host.wr(ADDR_ENABLE, 8'h25);
      dn(0, 1);
      cmp({15'h0000, intPinOe}, 16'h0001);
      i_host.wr(ADDR_ENABLE, 8'h00);
      clr(8'h07, 1'b0);
      $display("test prox interrupt done");
      i_host.wr(ADDR_LIGHT_LOW_LO, 8'h10);
      i_host.wr(ADDR_LIGHT_LOW_HI, 8'h00);
      i_host.wr(ADDR_LIGHT_HIGH_LO, 8'h20);
      i_host.wr(ADDR_LIGHT_HIGH_HI, 8'h00);
      i_host.wr(ADDR_PERSIST, 8'h14);
      channel0Result <= 16'h0030;
      i_host.wr(ADDR_ENABLE, 8'h13);
      dn(1, 4);
      cmp({15'h0000, intPinOe}, 16'h0000);
      dn(1, 1);
      cmp({15'h0000, intPinOe}, 16'h0001);
      clr(8'h05, 1'b1);
      clr(8'h06, 1'b0);
      i_host.wr(ADDR_PERSIST, 8'h01);
      dn(1, 1);
      cmp({15'h0000, intPinOe}, 16'h0001);
      $display("test light interrupt done");
      close_out();
   end
endmodule : test_lpt_timing_irq
`default_nettype wire
